// File: logic/hmt_pkg.sv
// Shared constants and types for the humidity/temperature readout block.
// Assumes a single 200 MHz core clock; all pin inputs are asynchronous to it.
package hmt_pkg;

  // Core clock rate, used to turn times into cycle counts
  localparam int unsigned CLK_KHZ = 200_000;

  // Register addresses (7-bit serial address)
  localparam logic [6:0] A_ID   = 7'h0f;
  localparam logic [6:0] A_RES  = 7'h10;
  localparam logic [6:0] A_CR1  = 7'h20;
  localparam logic [6:0] A_CR2  = 7'h21;
  localparam logic [6:0] A_CR3  = 7'h22;
  localparam logic [6:0] A_STAT = 7'h27;
  localparam logic [6:0] A_HUML = 7'h28;
  localparam logic [6:0] A_HUMH = 7'h29;
  localparam logic [6:0] A_TMPL = 7'h2a;
  localparam logic [6:0] A_TMPH = 7'h2b;

  // Field positions
  localparam int TRES_LSB    = 3;
  localparam int HRES_LSB    = 0;
  localparam int ACTIVE_BIT  = 7;
  localparam int HOLD_BIT    = 2;
  localparam int RATE_LSB    = 0;
  localparam int BOOT_BIT    = 7;
  localparam int ONESHOT_BIT = 0;
  localparam int POL_BIT     = 7;
  localparam int OD_BIT      = 6;
  localparam int RDYEN_BIT   = 2;

  // Writable bits; everything else is reserved and reads zero
  localparam logic [7:0] RES_WMASK = 8'h1b;
  localparam logic [7:0] CR1_WMASK = 8'h87;
  localparam logic [7:0] CR2_WMASK = 8'h81;
  localparam logic [7:0] CR3_WMASK = 8'hc4;

  // Reset values
  localparam logic [7:0] RES_RST = 8'h00;
  localparam logic [7:0] CR1_RST = 8'h00;
  localparam logic [7:0] CR2_RST = 8'h00;
  localparam logic [7:0] CR3_RST = 8'h00;

  // Mode-select pin code for stand-alone pulse-width output
  localparam logic [1:0] SEL_PWM = 2'b01;

  // Timing, in the units named
  localparam int unsigned RATE_1HZ_MS  = 1000;
  localparam int unsigned RATE_02HZ_MS = 5000;
  localparam int unsigned RATE_01HZ_MS = 10000;
  localparam int unsigned CONV_MS      = 16;
  localparam int unsigned PWM_HZ       = 120;
  localparam int unsigned PWM_MEAS_MS  = 500;
  localparam int unsigned BOOT_CYC     = 16;

  // Fixed resolutions in pulse-width mode
  localparam logic [4:0] PWM_HUM_BITS = 5'd10;
  localparam logic [4:0] PWM_TMP_BITS = 5'd12;

  // Synchronised pin bundle
  typedef struct packed {
    logic       cs_n;
    logic       sclk;
    logic       sdio;
    logic [1:0] sel;
  } hmt_pins_s;

  localparam hmt_pins_s PIN_IDLE = '{cs_n: 1'b1, sclk: 1'b1, sdio: 1'b0, sel: 2'b00};

  // One humidity/temperature result pair
  typedef struct packed {
    logic [15:0] hum;
    logic [15:0] tmp;
  } hmt_meas_s;

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_CONV} hmt_state_e;

endpackage

// File: logic/hmt_readout.sv
// Register readout, conversion sequencing and pin logic of the sensor.
// Assumes raw ADC words arrive on the core clock; serial pins are async.
`timescale 1ns/10ps
module hmt_readout
  import hmt_pkg::*;
#(
  parameter logic [7:0]  ID_CODE   = 8'h5a,  // Arbitrary identifier value
  parameter int unsigned RATE1_CYC = RATE_1HZ_MS * CLK_KHZ,
  parameter int unsigned RATE2_CYC = RATE_02HZ_MS * CLK_KHZ,
  parameter int unsigned RATE3_CYC = RATE_01HZ_MS * CLK_KHZ,
  parameter int unsigned CONV_CYC  = CONV_MS * CLK_KHZ,
  parameter int unsigned PWM_CYC   = CLK_KHZ * 1000 / PWM_HZ,
  parameter int unsigned PMEAS_CYC = PWM_MEAS_MS * CLK_KHZ
)
(
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       clk_en_in,
  // Serial port and mode pins
  input  wire logic       chip_select_n_in,
  input  wire logic       serial_clock_in,
  input  wire logic       sdio_in,
  output logic            sdio_out,
  output logic            sdio_oe_out,
  input  wire logic [1:0] mode_sel_in,
  // Data-ready pin
  output logic            ready_pin_out,
  output logic            ready_pin_oe_out,
  // Converter and fuse side
  input  wire hmt_meas_s  raw_in,
  input  wire logic [7:0] fuse_trim_in,
  output logic [7:0]      trim_out,
  output logic            conv_busy_out
);

  function automatic logic [15:0] res_mask(input logic [15:0] v, input logic [4:0] bits);
    res_mask = v & ~((16'h0001 << (5'd16 - bits)) - 16'h0001);
  endfunction

  function automatic logic [4:0] hum_bits(input logic [1:0] code);
    case (code)
      2'b00:   hum_bits = 5'd12;
      2'b01:   hum_bits = 5'd11;
      2'b10:   hum_bits = 5'd10;
      default: hum_bits = 5'd8;
    endcase
  endfunction

  hmt_pins_s  pin_s1_r, pin_s2_r;
  logic       sclk_d_r;
  logic       spi_on, sclk_rise, sclk_fall, pwm_mode;
  logic       hdr_done_r, rw_r, spi_oe_r, spi_bit_r;
  logic [2:0] bit_idx_r;
  logic [6:0] addr_r, wr_addr_r, rd_addr_r;
  logic [7:0] shin_r, shout_r, wr_data_r, rd_data;
  logic       wr_stb_r, rd_stb_r;
  logic [7:0] res_r, cr1_r, cr2_r, cr3_r, trim_r;
  logic       hflag_r, tflag_r;
  logic       h_lo_r, h_hi_r, t_lo_r, t_hi_r, lock_h, lock_t;
  hmt_state_e state_r;
  logic [31:0] cnt_r, rate_cnt_r, period, pwm_cnt_r, thr_r;
  logic       due_r, os_src_r, conv_done_r, boot_done_r, os_done_r, start_conv;
  hmt_meas_s  meas_r;
  logic [15:0] pwm_val;
  logic [47:0] pwm_prod;
  logic       active, hold, rdy_lvl;

  assign active = cr1_r[ACTIVE_BIT];
  assign hold   = cr1_r[HOLD_BIT];

  // Two-stage synchronisers; third sclk stage only reads the second
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      sclk_d_r <= 1'b1;
    end
    else if (clk_en_in)
    begin
      pin_s1_r <= '{cs_n: chip_select_n_in, sclk: serial_clock_in, sdio: sdio_in,
                    sel: mode_sel_in};
      pin_s2_r <= pin_s1_r;
      sclk_d_r <= pin_s2_r.sclk;
    end
  end

  assign pwm_mode  = (pin_s2_r.sel == SEL_PWM);
  assign spi_on    = ~pin_s2_r.cs_n & ~pwm_mode;
  assign sclk_rise = pin_s2_r.sclk & ~sclk_d_r;
  assign sclk_fall = ~pin_s2_r.sclk & sclk_d_r;

  // Register read mux; unmapped addresses return zero
  always_comb
  begin
    rd_data = 8'h00;
    unique case (addr_r)
      A_ID:    rd_data = ID_CODE;
      A_RES:   rd_data = res_r;
      A_CR1:   rd_data = cr1_r;
      A_CR2:   rd_data = cr2_r;
      A_CR3:   rd_data = cr3_r;
      A_STAT:  rd_data = {6'b00_0000, hflag_r, tflag_r};
      A_HUML:  rd_data = meas_r.hum[7:0];
      A_HUMH:  rd_data = meas_r.hum[15:8];
      A_TMPL:  rd_data = meas_r.tmp[7:0];
      A_TMPH:  rd_data = meas_r.tmp[15:8];
      default: rd_data = 8'h00;
    endcase
  end

  // Serial slave: header then bytes, address auto-increments per byte
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hdr_done_r <= 1'b0;
      rw_r       <= 1'b0;
      bit_idx_r  <= 3'd0;
      addr_r     <= 7'h00;
      shin_r     <= 8'h00;
      shout_r    <= 8'h00;
      spi_oe_r   <= 1'b0;
      spi_bit_r  <= 1'b0;
      wr_stb_r   <= 1'b0;
      wr_addr_r  <= 7'h00;
      wr_data_r  <= 8'h00;
      rd_stb_r   <= 1'b0;
      rd_addr_r  <= 7'h00;
    end
    else if (clk_en_in)
    begin
      wr_stb_r <= 1'b0;
      rd_stb_r <= 1'b0;
      if (!spi_on)
      begin
        // frame ends on chip select high
        hdr_done_r <= 1'b0;
        bit_idx_r  <= 3'd0;
        spi_oe_r   <= 1'b0;
      end
      else if (sclk_rise)
      begin
        shin_r    <= {shin_r[6:0], pin_s2_r.sdio};
        bit_idx_r <= bit_idx_r + 3'd1;
        if (bit_idx_r == 3'd7)
        begin
          if (!hdr_done_r)
          begin
            hdr_done_r <= 1'b1;
            rw_r       <= shin_r[6];
            addr_r     <= {shin_r[5:0], pin_s2_r.sdio};
          end
          else if (!rw_r)
          begin
            wr_stb_r  <= 1'b1;
            wr_addr_r <= addr_r;
            wr_data_r <= {shin_r[6:0], pin_s2_r.sdio};
            addr_r    <= addr_r + 7'd1;
          end
        end
      end
      else if (sclk_fall && hdr_done_r && rw_r)
      begin
        spi_oe_r <= 1'b1;
        if (bit_idx_r == 3'd0)
        begin
          spi_bit_r <= rd_data[7];
          shout_r   <= {rd_data[6:0], 1'b0};
          rd_stb_r  <= 1'b1;
          rd_addr_r <= addr_r;
          addr_r    <= addr_r + 7'd1;
        end
        else
        begin
          spi_bit_r <= shout_r[7];
          shout_r   <= {shout_r[6:0], 1'b0};
        end
      end
    end
  end

  // Control registers; a software write in the same cycle beats a self-clear
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      res_r <= RES_RST;
      cr1_r <= CR1_RST;
      cr2_r <= CR2_RST;
      cr3_r <= CR3_RST;
    end
    else if (clk_en_in)
    begin
      if (boot_done_r)
        cr2_r[BOOT_BIT] <= 1'b0;
      if (os_done_r)
        cr2_r[ONESHOT_BIT] <= 1'b0;
      if (wr_stb_r)
      begin
        unique case (wr_addr_r)
          A_RES:   res_r <= wr_data_r & RES_WMASK;
          A_CR1:   cr1_r <= wr_data_r & CR1_WMASK;
          A_CR2:   cr2_r <= wr_data_r & CR2_WMASK;
          A_CR3:   cr3_r <= wr_data_r & CR3_WMASK;
          default: ;
        endcase
      end
    end
  end

  // Status flags; a new sample wins over a clearing read
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      hflag_r <= 1'b0;
      tflag_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (rd_stb_r && rd_addr_r == A_HUMH)
        hflag_r <= 1'b0;
      if (rd_stb_r && rd_addr_r == A_TMPH)
        tflag_r <= 1'b0;
      if (conv_done_r)
      begin
        hflag_r <= 1'b1;
        tflag_r <= 1'b1;
      end
    end
  end

  // pair lock: set once either byte read, released when both
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      h_lo_r <= 1'b0;
      h_hi_r <= 1'b0;
      t_lo_r <= 1'b0;
      t_hi_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (!hold)
      begin
        h_lo_r <= 1'b0;
        h_hi_r <= 1'b0;
        t_lo_r <= 1'b0;
        t_hi_r <= 1'b0;
      end
      else if (rd_stb_r)
      begin
        if (rd_addr_r == A_HUML)
          {h_lo_r, h_hi_r} <= h_hi_r ? 2'b00 : 2'b10;
        if (rd_addr_r == A_HUMH)
          {h_lo_r, h_hi_r} <= h_lo_r ? 2'b00 : 2'b01;
        if (rd_addr_r == A_TMPL)
          {t_lo_r, t_hi_r} <= t_hi_r ? 2'b00 : 2'b10;
        if (rd_addr_r == A_TMPH)
          {t_lo_r, t_hi_r} <= t_lo_r ? 2'b00 : 2'b01;
      end
    end
  end

  assign lock_h = hold & (h_lo_r | h_hi_r);
  assign lock_t = hold & (t_lo_r | t_hi_r);

  // rate period; pulse mode overrides with its own cadence
  always_comb
  begin
    unique case (cr1_r[RATE_LSB +: 2])
      2'b01:   period = RATE1_CYC;
      2'b10:   period = RATE2_CYC;
      default: period = RATE3_CYC;
    endcase
    if (pwm_mode)
      period = PMEAS_CYC;
  end

  // Periodic trigger; due stays pending until the engine takes it
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rate_cnt_r <= 32'h0000_0000;
      due_r      <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (start_conv)
        due_r <= 1'b0;
      if (pwm_mode || (active && cr1_r[RATE_LSB +: 2] != 2'b00))
      begin
        if (rate_cnt_r >= period - 32'd1)
        begin
          rate_cnt_r <= 32'h0000_0000;
          due_r      <= 1'b1;
        end
        else
          rate_cnt_r <= rate_cnt_r + 32'd1;
      end
      else
        rate_cnt_r <= 32'h0000_0000;
    end
  end

  // no conversion in power-down, except stand-alone mode
  // Pulse mode also waits for its timer, so it measures only at its own cadence
  assign start_conv = (state_r == ST_IDLE) && !cr2_r[BOOT_BIT]
                    && (pwm_mode ? due_r : (active && (cr2_r[ONESHOT_BIT] || due_r)));

  // Sequencer: fuse load at reset, reboot, conversions
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_r     <= ST_BOOT;
      cnt_r       <= 32'(BOOT_CYC - 1);
      trim_r      <= 8'h00;
      os_src_r    <= 1'b0;
      conv_done_r <= 1'b0;
      boot_done_r <= 1'b0;
      os_done_r   <= 1'b0;
    end
    else if (clk_en_in)
    begin
      conv_done_r <= 1'b0;
      boot_done_r <= 1'b0;
      os_done_r   <= 1'b0;
      unique case (state_r)
        ST_BOOT:
        begin
          if (cnt_r == 32'h0000_0000)
          begin
            trim_r      <= fuse_trim_in;
            boot_done_r <= 1'b1;
            state_r     <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 32'd1;
        end
        ST_IDLE:
        begin
          if (cr2_r[BOOT_BIT] && !boot_done_r)
          begin
            state_r <= ST_BOOT;
            cnt_r   <= 32'(BOOT_CYC - 1);
          end
          else if (start_conv)
          begin
            state_r  <= ST_CONV;
            cnt_r    <= 32'(CONV_CYC - 1);
            os_src_r <= cr2_r[ONESHOT_BIT] & ~pwm_mode;
          end
        end
        ST_CONV:
        begin
          if (cnt_r == 32'h0000_0000)
          begin
            conv_done_r <= 1'b1;
            os_done_r   <= os_src_r;
            state_r     <= ST_IDLE;
          end
          else
            cnt_r <= cnt_r - 32'd1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Result registers; lock holds a pair while software reads it
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      meas_r <= '0;
    else if (clk_en_in && state_r == ST_CONV && cnt_r == 32'h0000_0000)
    begin
      if (pwm_mode)
      begin
        meas_r.hum <= res_mask(raw_in.hum, PWM_HUM_BITS);
        meas_r.tmp <= res_mask(raw_in.tmp, PWM_TMP_BITS);
      end
      else
      begin
        if (!lock_h)
          meas_r.hum <= res_mask(raw_in.hum, hum_bits(res_r[HRES_LSB +: 2]));
        if (!lock_t)
          meas_r.tmp <= res_mask(raw_in.tmp, 5'd14 - {3'b000, res_r[TRES_LSB +: 2]});
      end
    end
  end

  // quantity chosen by clock pin level
  assign pwm_val  = pin_s2_r.sclk ? meas_r.hum : meas_r.tmp;
  assign pwm_prod = {32'h0000_0000, pwm_val} * {16'h0000, PWM_CYC};

  // duty threshold = value/65536 of the period
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      pwm_cnt_r <= 32'h0000_0000;
      thr_r     <= 32'h0000_0000;
    end
    else if (clk_en_in)
    begin
      thr_r     <= pwm_prod[47:16];
      pwm_cnt_r <= (pwm_cnt_r >= PWM_CYC - 32'd1) ? 32'h0000_0000 : pwm_cnt_r + 32'd1;
    end
  end

  assign rdy_lvl = (hflag_r | tflag_r) ^ cr3_r[POL_BIT];

  // Output flops; open-drain only ever pulls low
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sdio_out         <= 1'b0;
      sdio_oe_out      <= 1'b0;
      ready_pin_out    <= 1'b0;
      ready_pin_oe_out <= 1'b0;
      trim_out         <= 8'h00;
      conv_busy_out    <= 1'b0;
    end
    else if (clk_en_in)
    begin
      sdio_out      <= pwm_mode ? (pwm_cnt_r < thr_r) : spi_bit_r;
      sdio_oe_out   <= pwm_mode | spi_oe_r;
      trim_out      <= trim_r;
      conv_busy_out <= (state_r == ST_CONV);
      ready_pin_out    <= cr3_r[OD_BIT] ? 1'b0 : rdy_lvl;
      ready_pin_oe_out <= cr3_r[RDYEN_BIT] & (~cr3_r[OD_BIT] | ~rdy_lvl);
    end
  end

  hflag_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && rd_stb_r && rd_addr_r == A_HUMH && !conv_done_r |=> !hflag_r)
    else $error("humidity flag not cleared by high byte read");

  tflag_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && rd_stb_r && rd_addr_r == A_TMPH && !conv_done_r |=> !tflag_r)
    else $error("temperature flag not cleared by high byte read");

  status_set_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && conv_done_r |=> hflag_r && tflag_r)
    else $error("status flags not set after conversion");

  oneshot_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && os_done_r && !wr_stb_r |=> !cr2_r[ONESHOT_BIT])
    else $error("one-shot bit not cleared after conversion");

  reboot_clear_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && state_r == ST_BOOT && cnt_r == 32'h0000_0000 ##1 clk_en_in && !wr_stb_r
    |=> !cr2_r[BOOT_BIT] && trim_r == $past(fuse_trim_in, 2))
    else $error("reboot did not reload trim and clear bit");

  power_down_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && state_r == ST_IDLE && !active && !pwm_mode |=> state_r != ST_CONV)
    else $error("conversion started in power-down");

  temp_res_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && state_r == ST_CONV && cnt_r == 32'h0000_0000 && !pwm_mode && !lock_t
    && res_r[TRES_LSB +: 2] == 2'b11 |=> meas_r.tmp[4:0] == 5'b00000)
    else $error("temperature not truncated to 11 bits");

  hold_pair_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && lock_t && !pwm_mode |=> $stable(meas_r.tmp))
    else $error("locked temperature pair changed");

  ready_level_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && cr3_r[RDYEN_BIT] && !cr3_r[OD_BIT]
    |=> ready_pin_oe_out && ready_pin_out == $past(rdy_lvl))
    else $error("ready pin does not follow flags");

  sdio_idle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    clk_en_in && !pwm_mode && pin_s2_r.cs_n ##1 clk_en_in && !pwm_mode |=> !sdio_oe_out)
    else $error("data line driven outside a frame");

endmodule // hmt_readout

// File: bench/hmt_spi_master.sv
// Serial master model for the three-wire register port.
// Assumes the bench calls xfer; its clock stands high between frames.
`timescale 1ns/10ps
module hmt_spi_master
#(
  parameter int HALF_NS = 24
)
(
  // Device side of the data line
  input  wire logic dev_do_in,
  input  wire logic dev_oe_in,
  // Pins toward the device
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      line_out
);
  logic drv_r;
  logic oe_r;
  logic idle_r = 1'b0;

  // Released line wanders, so a stale bit never reads as data
  always #7 idle_r = ~idle_r;
  assign line_out = dev_oe_in ? dev_do_in : (oe_r ? drv_r : idle_r);

  initial
  begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    oe_r = 1'b0;
    drv_r = 1'b0;
  end

  task automatic xfer(input logic rd, input logic [6:0] adr, input int nb,
                      inout logic [15:0] d);
    logic [23:0] sh;
    sh = {rd, adr, (nb == 1) ? {d[7:0], 8'h00} : d};
    cs_n_out = 1'b0;
    #(HALF_NS);
    for (int i = 0; i < 8 + 8 * nb; i++)
    begin
      sclk_out = 1'b0;
      oe_r = (i < 8) || !rd;
      drv_r = sh[23 - i];
      #(HALF_NS);
      sclk_out = 1'b1;
      if (i >= 8)
        d = {d[14:0], line_out};
      #(HALF_NS);
    end
    cs_n_out = 1'b1;
    oe_r = 1'b0;
    #(4 * HALF_NS);
  endtask

  task automatic park(input logic lvl);
    sclk_out = lvl;
  endtask
endmodule // hmt_spi_master

// File: bench/testbench.sv
// Self-checking bench for the sensor readout block.
// Assumes the serial master model and the package are compiled first.
`timescale 1ns/10ps
module testbench;
  import hmt_pkg::*;
  localparam logic [7:0] IDV = 8'h3c;  // Arbitrary identifier value
  // Short counts keep the run brief
  localparam int unsigned R1C = 400;
  localparam int unsigned R2C = 600;
  localparam int unsigned R3C = 800;
  localparam int unsigned CVC = 50;
  localparam int unsigned PWC = 256;
  localparam int unsigned PMC = 800;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  hmt_meas_s  raw = '0;
  hmt_meas_s  old;
  logic [7:0] fuse = 8'h00;
  logic [7:0] trim;
  logic [7:0] res;
  logic [7:0] c3;
  logic [15:0] v;
  logic [15:0] h;
  logic [15:0] t;
  logic [15:0] n;
  logic       clk_en = 1'b1;
  logic [1:0] mode_sel = 2'b00;
  wire        cs_n, sclk, line, sdo, soe, rdy, rdy_oe, busy;
  int         errors = 0;
  int         tests_run = 0;
  int         seed = 32'h6d57a849;
  int         tb_bits [4] = '{14, 13, 12, 11};
  int         hb_bits [4] = '{12, 11, 10, 8};
  logic [6:0] ra [5] = '{A_RES, A_CR1, A_CR2, A_CR3, A_STAT};

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  hmt_spi_master m (.dev_do_in(sdo), .dev_oe_in(soe), .cs_n_out(cs_n),
    .sclk_out(sclk), .line_out(line));

  hmt_readout #(.ID_CODE(IDV), .RATE1_CYC(R1C), .RATE2_CYC(R2C), .RATE3_CYC(R3C),
    .CONV_CYC(CVC), .PWM_CYC(PWC), .PMEAS_CYC(PMC)) dut (.clk_in(clk),
    .resetn_in(resetn), .clk_en_in(clk_en), .chip_select_n_in(cs_n),
    .serial_clock_in(sclk), .sdio_in(line), .sdio_out(sdo), .sdio_oe_out(soe),
    .mode_sel_in(mode_sel), .ready_pin_out(rdy), .ready_pin_oe_out(rdy_oe),
    .raw_in(raw), .fuse_trim_in(fuse), .trim_out(trim), .conv_busy_out(busy));

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] x;
    x = {8'h00, d};
    m.xfer(1'b0, a, 1, x);
  endtask

  task automatic rchk(input logic [6:0] a, input int n, input logic [15:0] e);
    logic [15:0] x;
    x = 16'h0000;
    m.xfer(1'b1, a, n, x);
    chk(x, e);
  endtask

  // Bounded wait for one whole conversion
  task automatic conv();
    int k;
    for (k = 0; k < 900 && busy !== 1'b1; k++) @(negedge clk);
    chk(busy, 1'b1);
    for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
    chk(busy, 1'b0);
  endtask

  // Result keeps only the top bits of the chosen resolution
  function automatic logic [15:0] lal(input logic [15:0] x, input int b);
    return x & ~(16'hffff >> b);
  endfunction

  // Pulse high time is value/65536 of the period
  function automatic logic [15:0] duty(input logic [15:0] x);
    return 16'((32'(x) * PWC) >> 16);
  endfunction

  // High cycles over one whole pulse period
  task automatic hi_cnt(output logic [15:0] c);
    c = 16'h0000;
    repeat (PWC)
    begin
      @(negedge clk);
      c = c + {15'h0000, sdo};
    end
  endtask

  // Expected {enable, level} of the data-ready pin
  function automatic logic [1:0] rexp(input logic [7:0] c, input logic f);
    logic lv;
    lv = f ^ c[POL_BIT];
    return c[OD_BIT] ? {c[RDYEN_BIT] & ~lv, 1'b0} : {c[RDYEN_BIT], lv};
  endfunction

  task automatic results();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog well beyond the expected run time
  initial
  begin
    #400_000;
    errors++;
    results();
  end

  initial
  begin
    fuse = 8'($random(seed));
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    repeat (24) @(negedge clk);
    chk(trim, fuse);
    rchk(A_ID, 1, IDV);
    foreach (ra[i]) rchk(ra[i], 1, 16'h0000);
    rchk(7'h30, 1, 16'h0000);
    wr(A_ID, 8'hff);
    rchk(A_ID, 1, IDV);
    wr(A_CR1, 8'h80);
    // Fixed then random resolutions and pin setups, random samples, one-shot each
    for (int it = 0; it < 5; it++)
    begin
      res = (it == 0) ? 8'hff : 8'($random(seed));
      c3 = (it == 0) ? 8'h00 : 8'($random(seed));
      @(negedge clk);
      raw = $random(seed);
      wr(A_RES, res);
      rchk(A_RES, 1, res & RES_WMASK);
      wr(A_CR3, c3);
      rchk(A_CR3, 1, c3 & CR3_WMASK);
      wr(A_CR2, 8'h01);
      conv();
      rchk(A_CR2, 1, 16'h0000);
      rchk(A_STAT, 1, 16'h0003);
      chk(rexp(c3, 1'b1), {rdy_oe, rdy});
      h = lal(raw.hum, hb_bits[res[1:0]]);
      t = lal(raw.tmp, tb_bits[res[4:3]]);
      rchk(A_HUML, 2, {h[7:0], h[15:8]});
      rchk(A_STAT, 1, 16'h0001);
      chk(rexp(c3, 1'b1), {rdy_oe, rdy});
      rchk(A_TMPL, 2, {t[7:0], t[15:8]});
      rchk(A_STAT, 1, 16'h0000);
      chk(rexp(c3, 1'b0), {rdy_oe, rdy});
    end
    // Pair held after a low-byte read
    wr(A_CR1, 8'h84);
    old = raw;
    wr(A_CR2, 8'h01);
    conv();
    rchk(A_HUML, 1, lal(old.hum, hb_bits[res[1:0]]) & 16'h00ff);
    @(negedge clk);
    raw = ~old;
    wr(A_CR2, 8'h01);
    conv();
    rchk(A_HUMH, 1, lal(old.hum, hb_bits[res[1:0]]) >> 8);
    // Both flags set again, the high byte read then clears humidity
    rchk(A_STAT, 1, 16'h0001);
    // Each periodic rate starts conversions unasked
    for (int r = 1; r < 4; r++)
    begin
      wr(A_CR1, 8'h80 | r[7:0]);
      // First pass still shows the humidity that the hold kept
      v = (r == 1) ? old.hum : raw.hum;
      rchk(A_HUMH, 1, lal(v, hb_bits[res[1:0]]) >> 8);
      rchk(A_TMPH, 1, lal(raw.tmp, tb_bits[res[4:3]]) >> 8);
      conv();
      rchk(A_STAT, 1, 16'h0003);
    end
    // Power-down keeps a one-shot pending
    wr(A_CR1, 8'h00);
    repeat (100) @(negedge clk);
    wr(A_CR2, 8'h01);
    repeat (200) @(negedge clk);
    chk(busy, 1'b0);
    rchk(A_CR2, 1, 16'h0001);
    // Clock enable low freezes the conversion that waking up starts
    wr(A_CR1, 8'h80);
    @(negedge clk);
    chk(busy, 1'b1);
    clk_en = 1'b0;
    repeat (100) @(negedge clk);
    chk(busy, 1'b1);
    clk_en = 1'b1;
    conv();
    rchk(A_CR2, 1, 16'h0000);
    @(negedge clk);
    fuse = ~fuse;
    wr(A_CR2, 8'h80);
    repeat (60) @(negedge clk);
    chk(trim, fuse);
    rchk(A_CR2, 1, 16'h0000);
    // Stand-alone pulse mode: duty carries the fixed-resolution value
    @(negedge clk);
    raw = $random(seed);
    mode_sel = SEL_PWM;
    conv();
    repeat (6) @(negedge clk);
    chk(soe, 1'b1);
    hi_cnt(n);
    chk(n, duty(lal(raw.hum, 10)));
    m.park(1'b0);
    repeat (6) @(negedge clk);
    hi_cnt(n);
    chk(n, duty(lal(raw.tmp, 12)));
    results();
  end
endmodule // testbench
